// >>> mfpb_port_bank.sv
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - group A: three outputs, five bidirectional pins
// - drive-select 0 sinks only, 1 pushes-pulls
// - reset: A latch all ones, drive-select zero
// - A latch and pin levels read separately
// - A pin/drive bits 7..5 read zero
// - B LCD-select 1 hands pin to LCD
// - B direction 1 drives latch, else input
// - reset clears B latch, direction, LCD-select
// - B read: pin, zero or latch
// - C direction 1 drives latch always
// - C read: zero, pin or latch
// - reset clears C latch, direction; enables inputs
// - B and C bit operations write input levels back
// - pins sampled at take, outputs after write
module mfpb_port_bank (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// wishbone slave
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [mfpb_pkg::ADR_W-1:0]    wb_adr_i,
	input  wire logic [31:0]                   wb_dat_i,
	input  wire logic [3:0]                    wb_sel_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	// group A
	input  wire logic [mfpb_pkg::DATA_W-1:0]   grp_a_periph_i,
	input  wire logic [mfpb_pkg::A_BIDIR_W-1:0] grp_a_pin_i,
	output logic      [mfpb_pkg::A_BIDIR_W-1:0] grp_a_pin_o,
	output logic      [mfpb_pkg::A_BIDIR_W-1:0] grp_a_pin_oe_o,
	output logic      [mfpb_pkg::A_OUT_W-1:0]   grp_a_out_o,
	// group B
	input  wire logic [mfpb_pkg::DATA_W-1:0]   grp_b_pin_i,
	input  wire logic [mfpb_pkg::DATA_W-1:0]   lcd_seg_i,
	output logic      [mfpb_pkg::DATA_W-1:0]   grp_b_pin_o,
	output logic      [mfpb_pkg::DATA_W-1:0]   grp_b_pin_oe_o,
	// group C
	input  wire logic [mfpb_pkg::DATA_W-1:0]   grp_c_pin_i,
	output logic      [mfpb_pkg::DATA_W-1:0]   grp_c_pin_o,
	output logic      [mfpb_pkg::DATA_W-1:0]   grp_c_pin_oe_o,
	output logic      [mfpb_pkg::DATA_W-1:0]   grp_c_digital_o
);

	localparam int W = mfpb_pkg::DATA_W;

	logic [W-1:0]                    grp_a_out_latch_r;
	logic [mfpb_pkg::A_BIDIR_W-1:0]  grp_a_drive_select_r;
	logic [W-1:0]                    grp_b_out_latch_r;
	logic [W-1:0]                    grp_b_direction_r;
	logic [W-1:0]                    grp_b_lcd_select_r;
	logic [W-1:0]                    grp_c_out_latch_r;
	logic [W-1:0]                    grp_c_direction_r;
	logic [W-1:0]                    grp_c_input_enable_r;
	logic [W-1:0]                    rd_data_r;
	logic [W-1:0]                    rd_data_nxt;
	logic [W-1:0]                    a_drive_val;
	logic [W-1:0]                    b_read_v;
	logic [W-1:0]                    c_read_v;
	logic [W-1:0]                    bop_mask;
	logic [mfpb_pkg::BITOP_IDX_W-1:0] bop_idx;
	logic                            bop_val;
	logic                            take;
	logic                            wr;
	logic [mfpb_pkg::ADR_W-1:0]      reg_adr;

	// data-address read per bit: input level, forced zero or latch
	function automatic logic [W-1:0] read_mix(input logic [W-1:0] pin, input logic [W-1:0] latch,
		input logic [W-1:0] dir, input logic [W-1:0] pin_ok);
		read_mix = (dir & latch) | (~dir & pin_ok & pin);
	endfunction : read_mix

	function automatic logic [W-1:0] bit_apply(input logic [W-1:0] base,
		input logic [mfpb_pkg::BITOP_IDX_W-1:0] idx, input logic val);
		logic [W-1:0] res;
		res      = base;
		res[idx] = val;
		bit_apply = res;
	endfunction : bit_apply

	mfpb_wb_slave u_slave (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wb_cyc_i  (wb_cyc_i),
		.wb_stb_i  (wb_stb_i),
		.wb_we_i   (wb_we_i),
		.wb_adr_i  (wb_adr_i),
		.wb_sel_i  (wb_sel_i),
		.wb_ack_o  (wb_ack_o),
		.take_o    (take),
		.wr_o      (wr),
		.reg_adr_o (reg_adr)
	);

	assign bop_idx  = wb_dat_i[mfpb_pkg::BITOP_IDX_LSB +: mfpb_pkg::BITOP_IDX_W];
	assign bop_val  = wb_dat_i[mfpb_pkg::BITOP_VAL_POS];
	assign bop_mask = bit_apply('0, bop_idx, 1'b1);

	// with direction 0, lcd-owned pins and disabled C inputs read zero
	assign b_read_v = read_mix(grp_b_pin_i, grp_b_out_latch_r, grp_b_direction_r, ~grp_b_lcd_select_r);
	assign c_read_v = read_mix(grp_c_pin_i, grp_c_out_latch_r, grp_c_direction_r, grp_c_input_enable_r);

	// group A registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grp_a_out_latch_r    <= mfpb_pkg::A_LATCH_RST;
			grp_a_drive_select_r <= mfpb_pkg::A_DRIVE_RST;
		end else if (wr) begin
			unique case (reg_adr)
				mfpb_pkg::OFS_A_LATCH: grp_a_out_latch_r <= wb_dat_i[W-1:0];
				mfpb_pkg::OFS_A_DRIVE: grp_a_drive_select_r <= wb_dat_i[mfpb_pkg::A_BIDIR_W-1:0];
				// A data address reads the latch, so nothing foreign leaks in
				mfpb_pkg::OFS_A_BITOP: grp_a_out_latch_r <= bit_apply(grp_a_out_latch_r, bop_idx, bop_val);
				default: ;
			endcase
		end
	end

	// group B registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grp_b_out_latch_r  <= mfpb_pkg::B_LATCH_RST;
			grp_b_direction_r  <= mfpb_pkg::B_DIR_RST;
			grp_b_lcd_select_r <= mfpb_pkg::B_LCD_RST;
		end else if (wr) begin
			unique case (reg_adr)
				mfpb_pkg::OFS_B_LATCH: grp_b_out_latch_r <= wb_dat_i[W-1:0];
				mfpb_pkg::OFS_B_DIR:   grp_b_direction_r <= wb_dat_i[W-1:0];
				mfpb_pkg::OFS_B_LCD:   grp_b_lcd_select_r <= wb_dat_i[W-1:0];
				// read-modify-write: input levels land in the latch
				mfpb_pkg::OFS_B_BITOP: grp_b_out_latch_r <= bit_apply(b_read_v, bop_idx, bop_val);
				default: ;
			endcase
		end
	end

	// group C registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grp_c_out_latch_r    <= mfpb_pkg::C_LATCH_RST;
			grp_c_direction_r    <= mfpb_pkg::C_DIR_RST;
			grp_c_input_enable_r <= mfpb_pkg::C_INEN_RST;
		end else if (wr) begin
			unique case (reg_adr)
				mfpb_pkg::OFS_C_LATCH: grp_c_out_latch_r <= wb_dat_i[W-1:0];
				mfpb_pkg::OFS_C_DIR:   grp_c_direction_r <= wb_dat_i[W-1:0];
				mfpb_pkg::OFS_C_INEN:  grp_c_input_enable_r <= wb_dat_i[W-1:0];
				// disabled inputs with direction 0 read zero, so bit operations clear those latches
				mfpb_pkg::OFS_C_BITOP: grp_c_out_latch_r <= bit_apply(c_read_v, bop_idx, bop_val);
				default: ;
			endcase
		end
	end

	// read mux, pins sampled on the edge that takes the request
	always_comb begin
		unique case (reg_adr)
			mfpb_pkg::OFS_A_LATCH: rd_data_nxt = grp_a_out_latch_r;
			mfpb_pkg::OFS_A_PIN:   rd_data_nxt = {{mfpb_pkg::A_OUT_W{1'b0}}, grp_a_pin_i};
			mfpb_pkg::OFS_A_DRIVE: rd_data_nxt = {{mfpb_pkg::A_OUT_W{1'b0}}, grp_a_drive_select_r};
			mfpb_pkg::OFS_B_LATCH: rd_data_nxt = b_read_v;
			mfpb_pkg::OFS_B_DIR:   rd_data_nxt = grp_b_direction_r;
			mfpb_pkg::OFS_B_LCD:   rd_data_nxt = grp_b_lcd_select_r;
			mfpb_pkg::OFS_C_LATCH: rd_data_nxt = c_read_v;
			mfpb_pkg::OFS_C_DIR:   rd_data_nxt = grp_c_direction_r;
			mfpb_pkg::OFS_C_INEN:  rd_data_nxt = grp_c_input_enable_r;
			default:               rd_data_nxt = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_r <= '0;
		end else if (take) begin
			rd_data_r <= rd_data_nxt;
		end
	end

	assign wb_dat_o = {24'h000000, rd_data_r};

	// group A pad drive: peripheral gated by latch
	assign a_drive_val = grp_a_out_latch_r & grp_a_periph_i;

	mfpb_drive_cell #(
		.W (mfpb_pkg::A_BIDIR_W)
	) u_a_cell (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.val_i       (a_drive_val[mfpb_pkg::A_BIDIR_W-1:0]),
		.push_pull_i (grp_a_drive_select_r),
		.pin_o       (grp_a_pin_o),
		.pin_oe_o    (grp_a_pin_oe_o)
	);

	// pins follow registers one edge later, matching the late output update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grp_a_out_o    <= mfpb_pkg::A_LATCH_RST[W-1:mfpb_pkg::A_BIDIR_W];
			grp_b_pin_o    <= '0;
			grp_b_pin_oe_o <= '0;
			grp_c_pin_o    <= '0;
			grp_c_pin_oe_o <= '0;
		end else begin
			grp_a_out_o    <= a_drive_val[W-1:mfpb_pkg::A_BIDIR_W];
			grp_b_pin_o    <= (grp_b_lcd_select_r & lcd_seg_i) | (~grp_b_lcd_select_r & grp_b_out_latch_r);
			grp_b_pin_oe_o <= grp_b_lcd_select_r | grp_b_direction_r;
			grp_c_pin_o    <= grp_c_out_latch_r;
			grp_c_pin_oe_o <= grp_c_direction_r;
		end
	end

	// disabled input buffer blocks toggling for analog or key-wake pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grp_c_digital_o <= '0;
		end else begin
			grp_c_digital_o <= grp_c_pin_i & grp_c_input_enable_r & ~grp_c_direction_r;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	reset_a_vals_a: assert property ($past(rst_i) |-> grp_a_out_latch_r == 8'hff && grp_a_drive_select_r == 5'h00
		&& grp_b_out_latch_r == 8'h00 && grp_b_lcd_select_r == 8'h00)
		else $error("group A/B reset values wrong");
	reset_c_vals_a: assert property ($past(rst_i) |-> grp_c_input_enable_r == 8'hff && grp_c_direction_r == 8'h00)
		else $error("group C reset values wrong");
	a_sink_only_a: assert property (!$past(rst_i) |-> (grp_a_pin_o & ~$past(grp_a_drive_select_r)) == 5'h00
		&& (grp_a_pin_oe_o & ~$past(grp_a_drive_select_r)) == (~$past(a_drive_val[4:0]) & ~$past(grp_a_drive_select_r)))
		else $error("open-drain pin drove high or missed a low");
	a_out_and_a: assert property (!$past(rst_i) |-> grp_a_out_o == $past(grp_a_out_latch_r[7:5] & grp_a_periph_i[7:5]))
		else $error("output-only pin not latch AND peripheral");
	b_lcd_owns_a: assert property (!$past(rst_i) |-> ((grp_b_pin_o ^ $past(lcd_seg_i)) & $past(grp_b_lcd_select_r)) == 8'h00
		&& (grp_b_pin_oe_o & $past(grp_b_lcd_select_r)) == $past(grp_b_lcd_select_r))
		else $error("lcd-selected pin not given to lcd");
	b_read_mix_a: assert property (take && !wb_we_i && reg_adr == mfpb_pkg::OFS_B_LATCH |=> wb_ack_o
		&& (wb_dat_o[7:0] & $past(grp_b_lcd_select_r & ~grp_b_direction_r)) == 8'h00
		&& ((wb_dat_o[7:0] ^ $past(grp_b_out_latch_r)) & $past(grp_b_direction_r)) == 8'h00)
		else $error("group B data read mixed wrongly");
	c_read_mix_a: assert property (take && !wb_we_i && reg_adr == mfpb_pkg::OFS_C_LATCH |=> wb_ack_o
		&& (wb_dat_o[7:0] & $past(~grp_c_input_enable_r & ~grp_c_direction_r)) == 8'h00
		&& ((wb_dat_o[7:0] ^ $past(grp_c_pin_i)) & $past(grp_c_input_enable_r & ~grp_c_direction_r)) == 8'h00)
		else $error("group C data read mixed wrongly");
	a_pin_read_a: assert property (take && !wb_we_i && reg_adr == mfpb_pkg::OFS_A_PIN |=>
		wb_dat_o == {27'h0000000, $past(grp_a_pin_i)})
		else $error("group A pin-level read wrong");
	c_drives_a: assert property (!$past(rst_i) |-> grp_c_pin_oe_o == $past(grp_c_direction_r))
		else $error("group C enable not following direction");
	b_writeback_a: assert property (wr && reg_adr == mfpb_pkg::OFS_B_BITOP |=>
		((grp_b_out_latch_r ^ $past(grp_b_pin_i)) & $past(~grp_b_direction_r & ~grp_b_lcd_select_r & ~bop_mask)) == 8'h00)
		else $error("bit operation lost input level write-back");
	ack_one_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after take");

	b_read_c: cover property (take && !wb_we_i && reg_adr == mfpb_pkg::OFS_B_LATCH ##1 wb_ack_o);
	c_bitop_c: cover property (wr && reg_adr == mfpb_pkg::OFS_C_BITOP);
	a_release_c: cover property (grp_a_pin_oe_o[0] ##1 !grp_a_pin_oe_o[0] && !grp_a_drive_select_r[0]);

endmodule : mfpb_port_bank

`default_nettype wire

// >>> mfpb_pkg.sv
package mfpb_pkg;

	// port widths
	localparam int DATA_W    = 8;
	localparam int A_BIDIR_W = 5;
	localparam int A_OUT_W   = 3;
	localparam int ADR_W     = 8;

	// register byte addresses
	localparam logic [7:0] OFS_A_LATCH   = 8'h00;
	localparam logic [7:0] OFS_A_PIN     = 8'h04;
	localparam logic [7:0] OFS_A_DRIVE   = 8'h08;
	localparam logic [7:0] OFS_B_LATCH   = 8'h0c;
	localparam logic [7:0] OFS_B_DIR     = 8'h10;
	localparam logic [7:0] OFS_B_LCD     = 8'h14;
	localparam logic [7:0] OFS_C_LATCH   = 8'h18;
	localparam logic [7:0] OFS_C_DIR     = 8'h1c;
	localparam logic [7:0] OFS_C_INEN    = 8'h20;
	localparam logic [7:0] OFS_A_BITOP   = 8'h24;
	localparam logic [7:0] OFS_B_BITOP   = 8'h28;
	localparam logic [7:0] OFS_C_BITOP   = 8'h2c;

	// bit-operation write word: bit index and new value
	localparam int BITOP_IDX_LSB = 0;
	localparam int BITOP_IDX_W   = 3;
	localparam int BITOP_VAL_POS = 3;

	// values after reset
	localparam logic [7:0] A_LATCH_RST = 8'hff;
	localparam logic [4:0] A_DRIVE_RST = 5'h00;
	localparam logic [7:0] B_LATCH_RST = 8'h00;
	localparam logic [7:0] B_DIR_RST   = 8'h00;
	localparam logic [7:0] B_LCD_RST   = 8'h00;
	localparam logic [7:0] C_LATCH_RST = 8'h00;
	localparam logic [7:0] C_DIR_RST   = 8'h00;
	localparam logic [7:0] C_INEN_RST  = 8'hff;

	typedef enum logic {MFPB_BUS_IDLE, MFPB_BUS_ACK} mfpb_bus_t;

endpackage : mfpb_pkg

// >>> mfpb_wb_slave.sv
`timescale 1ns/1ns
`default_nettype none

module mfpb_wb_slave (
	// clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// wishbone request
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [mfpb_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	output logic                           wb_ack_o,
	// decoded access
	output logic                           take_o,
	output logic                           wr_o,
	output logic [mfpb_pkg::ADR_W-1:0]     reg_adr_o
);

	mfpb_pkg::mfpb_bus_t state_r;

	// the ack state blocks a second take while the master still holds the request
	assign take_o    = wb_cyc_i && wb_stb_i && (state_r == mfpb_pkg::MFPB_BUS_IDLE);
	assign wr_o      = take_o && wb_we_i && wb_sel_i[0];
	assign reg_adr_o = {wb_adr_i[mfpb_pkg::ADR_W-1:2], 2'b00};
	assign wb_ack_o  = (state_r == mfpb_pkg::MFPB_BUS_ACK);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= mfpb_pkg::MFPB_BUS_IDLE;
		end else begin
			unique case (state_r)
				mfpb_pkg::MFPB_BUS_IDLE: begin
					if (take_o) begin
						state_r <= mfpb_pkg::MFPB_BUS_ACK;
					end
				end
				mfpb_pkg::MFPB_BUS_ACK: begin
					state_r <= mfpb_pkg::MFPB_BUS_IDLE;
				end
			endcase
		end
	end

endmodule : mfpb_wb_slave

`default_nettype wire

// >>> mfpb_drive_cell.sv
`timescale 1ns/1ns
`default_nettype none

module mfpb_drive_cell #(
	parameter int W = 5
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// wanted level and drive kind per pin
	input  wire logic [W-1:0] val_i,
	input  wire logic [W-1:0] push_pull_i,
	// pad side
	output logic      [W-1:0] pin_o,
	output logic      [W-1:0] pin_oe_o
);

	if (W < 1) begin : g_bad_w
		$error("mfpb_drive_cell: W must be at least 1");
	end

	// sink-only drive never pushes a high; a 1 simply lets go of the pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o    <= '0;
			pin_oe_o <= '0;
		end else begin
			pin_o    <= val_i & push_pull_i;
			pin_oe_o <= push_pull_i | ~val_i;
		end
	end

endmodule : mfpb_drive_cell

`default_nettype wire

// >>> mfpb_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

// far side of the pads: wire level is the driving party's value
module mfpb_pin_model (
	// design drive
	input  wire logic [4:0] a_o_i,
	input  wire logic [4:0] a_oe_i,
	input  wire logic [7:0] b_o_i,
	input  wire logic [7:0] b_oe_i,
	input  wire logic [7:0] c_o_i,
	input  wire logic [7:0] c_oe_i,
	// external sources, always driving when the pad is released
	input  wire logic [4:0] ext_a_i,
	input  wire logic [7:0] ext_b_i,
	input  wire logic [7:0] ext_c_i,
	// resolved levels back to the design
	output logic      [4:0] a_lvl_o,
	output logic      [7:0] b_lvl_o,
	output logic      [7:0] c_lvl_o
);
	// a released open-drain pad follows the outside source, never the stale drive
	assign a_lvl_o = (a_oe_i & a_o_i) | (~a_oe_i & ext_a_i);
	assign b_lvl_o = (b_oe_i & b_o_i) | (~b_oe_i & ext_b_i);
	assign c_lvl_o = (c_oe_i & c_o_i) | (~c_oe_i & ext_c_i);
endmodule : mfpb_pin_model

`default_nettype wire

// >>> mfpb_port_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end

module mfpb_port_bank_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat_o;
	logic        ack;
	logic [7:0]  periph = 8'hff, seg = 8'h00, ext_b = 8'h00, ext_c = 8'h00;
	logic [4:0]  ext_a = 5'h00;
	logic [4:0]  a_o, a_oe, a_lvl;
	logic [2:0]  a_out;
	logic [7:0]  b_o, b_oe, b_lvl, c_o, c_oe, c_lvl, c_dig;
	logic [15:0] exp_q[$];
	logic [15:0] note;
	logic [31:0] seed = 32'd29899;
	int          err_count = 0;
	int          checks = 0;

	always #4 clk_i = ~clk_i;

	mfpb_port_bank uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.grp_a_periph_i(periph), .grp_a_pin_i(a_lvl), .grp_a_pin_o(a_o), .grp_a_pin_oe_o(a_oe),
		.grp_a_out_o(a_out), .grp_b_pin_i(b_lvl), .lcd_seg_i(seg), .grp_b_pin_o(b_o),
		.grp_b_pin_oe_o(b_oe), .grp_c_pin_i(c_lvl), .grp_c_pin_o(c_o), .grp_c_pin_oe_o(c_oe),
		.grp_c_digital_o(c_dig));

	mfpb_pin_model pins (.a_o_i(a_o), .a_oe_i(a_oe), .b_o_i(b_o), .b_oe_i(b_oe), .c_o_i(c_o),
		.c_oe_i(c_oe), .ext_a_i(ext_a), .ext_b_i(ext_b), .ext_c_i(ext_c), .a_lvl_o(a_lvl),
		.b_lvl_o(b_lvl), .c_lvl_o(c_lvl));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic test_done();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	// every access leaves a note {mask, expected}; mask zero means acked only
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
		input logic [15:0] n);
		int k;
		k = 0;
		exp_q.push_back(n);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d}; sel <= s;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (k >= 50) begin
			err_count++;
			$display("Error ack expected 1 seen %b", ack);
			test_done();
		end
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1, 16'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		bus(1'b0, a, 8'h00, 4'h1, {m, e & m});
	endtask : rd

	// pins move one edge after the write, so look at the falling edge after two more rising edges
	task automatic settle();
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
	endtask : settle

	always @(posedge clk_i) begin
		if (!rst_i && ack === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("Error ack expected 0 seen 1");
			end else begin
				note = exp_q.pop_front();
				if (note[15:8] != 8'h00)
					`CHK("rd_data", note[7:0], dat_o[7:0] & note[15:8])
			end
		end
	end

	initial begin
		#(8 * 20000);
		err_count++;
		$display("Error watchdog expected done seen hang");
		test_done();
	end

	initial begin : main
		logic [7:0] l, d, p, e, r, s, x, eo, eoe;
		logic [2:0] ix;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		`CHK("a_out", 3'h7, a_out)
		rd(mfpb_pkg::OFS_A_LATCH, mfpb_pkg::A_LATCH_RST, 8'hff);
		rd(mfpb_pkg::OFS_A_DRIVE, 8'h00, 8'h1f);
		rd(mfpb_pkg::OFS_B_DIR, 8'h00, 8'hff);
		rd(mfpb_pkg::OFS_B_LCD, 8'h00, 8'hff);
		rd(mfpb_pkg::OFS_C_DIR, 8'h00, 8'hff);
		rd(mfpb_pkg::OFS_C_INEN, mfpb_pkg::C_INEN_RST, 8'hff);
		wr(mfpb_pkg::OFS_B_DIR, 8'hff);
		rd(mfpb_pkg::OFS_B_LATCH, 8'h00, 8'hff);
		wr(mfpb_pkg::OFS_C_DIR, 8'hff);
		rd(mfpb_pkg::OFS_C_LATCH, 8'h00, 8'hff);
		// refused writes: read-only pin register, sel0 low, unmapped place
		wr(mfpb_pkg::OFS_A_PIN, 8'h00);
		bus(1'b1, mfpb_pkg::OFS_A_LATCH, 8'h00, 4'he, 16'h0);
		wr(8'h30, 8'h00);
		rd(8'h30, 8'h00, 8'hff);
		rd(mfpb_pkg::OFS_A_LATCH, 8'hff, 8'hff);
		for (int i = 0; i < 8; i++) begin
			l = xs(); d = xs(); p = xs(); e = xs();
			@(posedge clk_i);
			periph <= p; ext_a <= e[4:0];
			wr(mfpb_pkg::OFS_A_LATCH, 8'hff);
			wr(mfpb_pkg::OFS_A_DRIVE, {3'h0, d[4:0]});
			wr(mfpb_pkg::OFS_A_LATCH, l);
			settle();
			x = l & p;
			eo = {3'h0, x[4:0] & d[4:0]};
			eoe = {3'h0, d[4:0] | ~x[4:0]};
			`CHK("a_pin_o", eo[4:0], a_o)
			`CHK("a_pin_oe", eoe[4:0], a_oe)
			`CHK("a_out", x[7:5], a_out)
			rd(mfpb_pkg::OFS_A_LATCH, l, 8'hff);
			rd(mfpb_pkg::OFS_A_PIN, (eoe & eo) | (~eoe & {3'h0, e[4:0]}), 8'h1f);
			x = xs();
			l[x[2:0]] = x[3];
			wr(mfpb_pkg::OFS_A_BITOP, {4'h0, x[3:0]});
			rd(mfpb_pkg::OFS_A_LATCH, l, 8'hff);
			l = xs(); d = xs(); p = xs(); s = xs(); e = xs();
			@(posedge clk_i);
			seg <= s; ext_b <= e;
			wr(mfpb_pkg::OFS_B_LATCH, l);
			wr(mfpb_pkg::OFS_B_DIR, d);
			wr(mfpb_pkg::OFS_B_LCD, p);
			settle();
			`CHK("b_pin_o", (p & s) | (~p & l), b_o)
			`CHK("b_pin_oe", p | d, b_oe)
			r = (d & l) | (~d & ~p & e);
			rd(mfpb_pkg::OFS_B_LATCH, r, 8'hff);
			x = xs();
			ix = x[2:0];
			x = xs();
			r[ix] = x[0];
			wr(mfpb_pkg::OFS_B_BITOP, {4'h0, x[0], ix});
			wr(mfpb_pkg::OFS_B_DIR, 8'hff);
			rd(mfpb_pkg::OFS_B_LATCH, r, 8'hff);
			l = xs(); d = xs(); p = xs(); e = xs();
			@(posedge clk_i);
			ext_c <= e;
			wr(mfpb_pkg::OFS_C_DIR, d);
			wr(mfpb_pkg::OFS_C_INEN, p);
			wr(mfpb_pkg::OFS_C_LATCH, l);
			settle();
			`CHK("c_pin_o", l, c_o)
			`CHK("c_pin_oe", d, c_oe)
			`CHK("c_digital", e & p & ~d, c_dig)
			rd(mfpb_pkg::OFS_C_LATCH, (d & l) | (~d & p & e), 8'hff);
			r = (d & l) | (~d & p & e);
			x = xs();
			r[x[2:0]] = x[3];
			wr(mfpb_pkg::OFS_C_BITOP, {4'h0, x[3:0]});
			wr(mfpb_pkg::OFS_C_DIR, 8'hff);
			rd(mfpb_pkg::OFS_C_LATCH, r, 8'hff);
		end
		// analog use of group C
		wr(mfpb_pkg::OFS_C_LATCH, 8'h00);
		wr(mfpb_pkg::OFS_C_DIR, 8'h00);
		wr(mfpb_pkg::OFS_C_INEN, 8'h00);
		// no port writes while a conversion would run
		repeat (4) @(posedge clk_i);
		ext_c <= 8'hff;
		settle();
		`CHK("c_digital", 8'h00, c_dig)
		`CHK("c_pin_oe", 8'h00, c_oe)
		rd(mfpb_pkg::OFS_C_LATCH, 8'h00, 8'hff);
		repeat (2) @(posedge clk_i);
		test_done();
	end
endmodule : mfpb_port_bank_tb

`default_nettype wire
